// >>> bsts_top.sv
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "bsts_params.svh"
// Overview of operation
// - Die overheat drops core, switches, port and legacy sink and holds boot; roles and PD stay.
// - Die shutdown ends once the die cools past hysteresis.
// - Each power path has its own over-temperature shutdown.
// - Cooled path resumes by itself or on firmware, per control bit.
// - Core clock plus slow timer clock, also core clock in low power.
// - Boot initialises state, then loads configuration bundles.
// - Straps give a dead-battery mode and a default configuration.
// - Strap high: ratio bands give mode and safe or wait default.
// - Strap low, lower bands: profiles 1 to 3 and retry modes.
// - Strap low, upper bands: profile 4, reserved and profile 5.
// - No-response: no switch closed, start-up waits for aux supply.
// - Wait-aux: sink switch closed, no loading until aux supply.
// - Retry modes: sink switch closed, load retried forever.
// - No-wait: load on VBUS, then close the loaded switch choice.
// - External modes drive the sink pin; internal use first path.
// - Always try loading configuration over serial interfaces.
// - Default configuration applies only when loading fails.
// - Safe default: ports off, legacy sink when powered from VBUS.
// - Infinite-wait default stays in boot awaiting configuration.
// - Profile 1: source only, internal switch, no PD messaging.
// - Profiles 2 and 4: source only via internal switch, no alt modes.
// - Profiles 3 and 5 sink; 5 uses external switch, also sources.
module bsts_top #(
    parameter int NPATH = 2
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic DIGITAL_STRAP_INPUT,
    input wire logic [6:0] DIVIDER_RATIO_PCT,
    input wire logic AUX_SUPPLY_INPUT,
    input wire logic DIE_OVER_TEMP,
    input wire logic DIE_COOLED,
    input wire logic [NPATH-1:0] PATH_OVER_TEMP,
    input wire logic [NPATH-1:0] PATH_COOLED,
    input wire logic CFG_LOAD_DONE,
    input wire logic CFG_LOAD_FAIL,
    input wire logic [2:0] CFG_SINK_SEL,
    output logic CFG_LOAD_REQ,
    output logic [NPATH-1:0] HIGH_VOLTAGE_PATH_EN,
    output logic EXTERNAL_SINK_CONTROL_PIN,
    output logic CORE_ENABLE,
    output logic CORE_CLK_LOW_POWER,
    output logic PORT_ENABLE,
    output logic LEGACY_SINK,
    output logic SOURCE_ROLE,
    output logic SINK_ROLE,
    output logic PD_MSG_ENABLE,
    output logic BOOT_DONE,
    output bsts_pkg::bsts_db_mode_t DB_MODE,
    output bsts_pkg::bsts_dcfg_t DEFAULT_CFG
);
    import bsts_pkg::*;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam int TICK_DIV = `BSTS_CLK_HZ / `BSTS_SLOW_HZ;
    localparam int INIT_TK = (`BSTS_INIT_US * (`BSTS_SLOW_HZ / 1000)
        + 999) / 1000;
    localparam int RETRY_TK = (`BSTS_RETRY_US * (`BSTS_SLOW_HZ / 1000)
        + 999) / 1000;
    localparam logic [15:0] INIT_N = 16'(INIT_TK < 1 ? 1 : INIT_TK);
    localparam logic [15:0] RETRY_N = 16'(RETRY_TK < 1 ? 1 : RETRY_TK);

    bsts_state_t state_q;
    bsts_db_mode_t db_q;
    bsts_dcfg_t dc_q;
    logic [1:0] ctrl_q;
    logic [15:0] tmr_q;
    logic tick;
    logic die_sd_q;
    logic [NPATH-1:0] path_off_q;
    logic [NPATH-1:0] reen_pulse;
    logic loaded_q;
    logic dflt_q;
    logic dead_batt;
    logic is_retry;
    logic wr_acc;
    bsts_db_mode_t db_d;
    bsts_dcfg_t dc_d;
    logic [NPATH-1:0] hv_d;
    logic ext_d;

    // ------------------------------------------------------------
    // Slow timer tick
    // ------------------------------------------------------------
    bsts_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk(CLOCK),
        .rst(SRST),
        .tick(tick)
    );

    assign dead_batt = !AUX_SUPPLY_INPUT;
    assign is_retry = (db_q == DB_RETRY_INT) || (db_q == DB_RETRY_EXT);

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    always_comb begin
        logic [6:0] tens;
        logic [6:0] unit;
        logic in_band;
        tens = DIVIDER_RATIO_PCT / `BSTS_PCT_BAND;
        unit = DIVIDER_RATIO_PCT % `BSTS_PCT_BAND;
        in_band = (unit <= `BSTS_PCT_UNIT_MAX);
        db_d = DB_NO_RESPONSE;
        dc_d = DC_SAFE;
        if (DIGITAL_STRAP_INPUT) begin
            if (DIVIDER_RATIO_PCT >= `BSTS_PCT_HI_FREE) begin
                db_d = DB_NO_WAIT;
            end else if (in_band) begin
                case (tens)
                    7'd2: db_d = DB_WAIT_AUX_INT;
                    7'd3: begin
                        db_d = DB_RETRY_INT;
                        dc_d = DC_INF_WAIT;
                    end
                    7'd4: db_d = DB_WAIT_AUX_EXT;
                    7'd5: begin
                        db_d = DB_RETRY_EXT;
                        dc_d = DC_INF_WAIT;
                    end
                    default: db_d = DB_NO_RESPONSE;
                endcase
            end
        end else begin
            dc_d = DC_RESERVED;
            if (DIVIDER_RATIO_PCT >= `BSTS_PCT_LOW_MIN &&
                (in_band || DIVIDER_RATIO_PCT == `BSTS_PCT_FULL)) begin
                case (tens)
                    7'd1: dc_d = DC_PROF1;
                    7'd2: dc_d = DC_PROF2;
                    7'd3: begin
                        db_d = DB_RETRY_INT;
                        dc_d = DC_INF_WAIT;
                    end
                    7'd4: begin
                        db_d = DB_NO_WAIT;
                        dc_d = DC_PROF3;
                    end
                    7'd5: begin
                        db_d = DB_RETRY_EXT;
                        dc_d = DC_INF_WAIT;
                    end
                    7'd6: dc_d = DC_PROF4;
                    7'd7: db_d = DB_NO_WAIT;
                    7'd8: db_d = DB_NO_RESPONSE;
                    default: begin
                        db_d = DB_NO_WAIT;
                        dc_d = DC_PROF5;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            db_q <= DB_NO_RESPONSE;
            dc_q <= DC_SAFE;
        end else if (state_q == ST_STRAP) begin
            db_q <= db_d;
            dc_q <= dc_d;
        end
    end

    // ------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_q <= ST_STRAP;
            tmr_q <= 16'h0000;
            loaded_q <= 1'b0;
            dflt_q <= 1'b0;
            CFG_LOAD_REQ <= 1'b0;
        end else if (die_sd_q) begin
            CFG_LOAD_REQ <= 1'b0;
        end else begin
            CFG_LOAD_REQ <= 1'b0;
            case (state_q)
                ST_STRAP: begin
                    tmr_q <= 16'h0000;
                    state_q <= ST_INIT;
                end
                ST_INIT: begin
                    if (tick) begin
                        tmr_q <= tmr_q + 16'h0001;
                    end
                    if (tmr_q >= INIT_N) begin
                        if (dead_batt && (db_q == DB_NO_RESPONSE ||
                            db_q == DB_WAIT_AUX_INT ||
                            db_q == DB_WAIT_AUX_EXT)) begin
                            state_q <= ST_HOLD;
                        end else begin
                            state_q <= ST_LOAD;
                        end
                    end
                end
                ST_HOLD: begin
                    if (!dead_batt) begin
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    CFG_LOAD_REQ <= 1'b1;
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    tmr_q <= 16'h0000;
                    if (CFG_LOAD_DONE) begin
                        loaded_q <= 1'b1;
                        state_q <= ST_RUN;
                    end else if (CFG_LOAD_FAIL) begin
                        if (is_retry || dc_q == DC_INF_WAIT) begin
                            state_q <= ST_RETRY;
                        end else begin
                            dflt_q <= 1'b1;
                            state_q <= ST_RUN;
                        end
                    end
                end
                ST_RETRY: begin
                    if (tick) begin
                        tmr_q <= tmr_q + 16'h0001;
                    end
                    if (tmr_q >= RETRY_N) begin
                        state_q <= ST_LOAD;
                    end
                end
                ST_RUN: state_q <= ST_RUN;
                default: state_q <= ST_STRAP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Die thermal shutdown, set wins over cool-down
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            die_sd_q <= 1'b0;
        end else if (DIE_OVER_TEMP) begin
            die_sd_q <= 1'b1;
        end else if (DIE_COOLED) begin
            die_sd_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Per-path thermal shutdown
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            path_off_q <= '0;
        end else begin
            for (int i = 0; i < NPATH; i++) begin
                if (PATH_OVER_TEMP[i]) begin
                    path_off_q[i] <= 1'b1;
                end else if (PATH_COOLED[i] &&
                    (ctrl_q[`BSTS_CTRL_AUTO] || reen_pulse[i])) begin
                    path_off_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Sink switch selection
    // ------------------------------------------------------------
    always_comb begin
        hv_d = '0;
        ext_d = 1'b0;
        if (state_q != ST_RUN) begin
            if (dead_batt && (db_q == DB_WAIT_AUX_INT ||
                db_q == DB_RETRY_INT)) begin
                hv_d[0] = 1'b1;
            end
            if (dead_batt && (db_q == DB_WAIT_AUX_EXT ||
                db_q == DB_RETRY_EXT)) begin
                ext_d = 1'b1;
            end
        end else if (loaded_q) begin
            hv_d[0] = CFG_SINK_SEL[`BSTS_SEL_HV0];
            if (NPATH > 1) begin
                hv_d[NPATH-1] = CFG_SINK_SEL[`BSTS_SEL_HV1];
            end
            ext_d = CFG_SINK_SEL[`BSTS_SEL_EXT];
        end else if (dflt_q) begin
            case (dc_q)
                DC_SAFE: hv_d[0] = dead_batt;
                DC_PROF1, DC_PROF2, DC_PROF3, DC_PROF4:
                    hv_d[0] = 1'b1;
                DC_PROF5: ext_d = 1'b1;
                default: ext_d = 1'b0;
            endcase
        end
        hv_d = hv_d & ~path_off_q;
        if (die_sd_q) begin
            hv_d = '0;
            ext_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Device outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            HIGH_VOLTAGE_PATH_EN <= '0;
            EXTERNAL_SINK_CONTROL_PIN <= 1'b0;
            CORE_ENABLE <= 1'b0;
            PORT_ENABLE <= 1'b0;
            LEGACY_SINK <= 1'b0;
            SOURCE_ROLE <= 1'b0;
            SINK_ROLE <= 1'b0;
            PD_MSG_ENABLE <= 1'b0;
            BOOT_DONE <= 1'b0;
        end else begin
            HIGH_VOLTAGE_PATH_EN <= hv_d;
            EXTERNAL_SINK_CONTROL_PIN <= ext_d;
            CORE_ENABLE <= !die_sd_q;
            BOOT_DONE <= (state_q == ST_RUN);
            PORT_ENABLE <= !die_sd_q && (state_q == ST_RUN) &&
                !(dflt_q && dc_q == DC_SAFE);
            LEGACY_SINK <= !die_sd_q && dflt_q && dc_q == DC_SAFE &&
                dead_batt;
            SOURCE_ROLE <= dflt_q && (dc_q == DC_PROF1 ||
                dc_q == DC_PROF2 || dc_q == DC_PROF4 ||
                dc_q == DC_PROF5);
            SINK_ROLE <= dflt_q && (dc_q == DC_PROF3 ||
                dc_q == DC_PROF5);
            PD_MSG_ENABLE <= loaded_q || (dflt_q &&
                dc_q != DC_PROF1 && dc_q != DC_SAFE);
        end
    end

    assign DB_MODE = db_q;
    assign DEFAULT_CFG = dc_q;

    // ------------------------------------------------------------
    // APB slave, answers in the first access cycle
    // ------------------------------------------------------------
    assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
    assign reen_pulse = (wr_acc && PADDR == `BSTS_OFS_REEN) ?
        PWDATA[NPATH-1:0] : '0;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    `BSTS_OFS_CTRL: PRDATA[1:0] <= ctrl_q;
                    `BSTS_OFS_REEN: PRDATA <= 32'h0000_0000;
                    `BSTS_OFS_STAT: begin
                        PRDATA[`BSTS_ST_DB_LSB +: 3] <= db_q;
                        PRDATA[`BSTS_ST_CFG_LSB +: 3] <= dc_q;
                        PRDATA[`BSTS_ST_LOADED] <= loaded_q;
                        PRDATA[`BSTS_ST_DEFAULT] <= dflt_q;
                        PRDATA[`BSTS_ST_DIE] <= die_sd_q;
                        PRDATA[`BSTS_ST_PATH_LSB +: NPATH] <= path_off_q;
                        PRDATA[`BSTS_ST_BOOTED] <= (state_q == ST_RUN);
                    end
                    default: PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ctrl_q <= `BSTS_CTRL_RST;
            CORE_CLK_LOW_POWER <= 1'b0;
        end else begin
            if (wr_acc && PADDR == `BSTS_OFS_CTRL) begin
                ctrl_q <= PWDATA[1:0];
            end
            CORE_CLK_LOW_POWER <= ctrl_q[`BSTS_CTRL_LP];
        end
    end
endmodule

// >>> bsts_params.svh
`ifndef BSTS_PARAMS_SVH
`define BSTS_PARAMS_SVH

// ----------------------------------------------------------------
// Clocks
// ----------------------------------------------------------------
`define BSTS_CLK_HZ 20000000
`define BSTS_SLOW_HZ 100000
`define BSTS_US_PER_S 1000000

// ----------------------------------------------------------------
// Boot timing, in microseconds
// ----------------------------------------------------------------
`define BSTS_INIT_US 50
`define BSTS_RETRY_US 1000

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define BSTS_OFS_CTRL 12'h000
`define BSTS_OFS_REEN 12'h004
`define BSTS_OFS_STAT 12'h008
`define BSTS_CTRL_AUTO 0
`define BSTS_CTRL_LP 1
`define BSTS_CTRL_RST 2'b00
`define BSTS_ST_DB_LSB 0
`define BSTS_ST_CFG_LSB 4
`define BSTS_ST_LOADED 8
`define BSTS_ST_DEFAULT 9
`define BSTS_ST_DIE 10
`define BSTS_ST_PATH_LSB 12
`define BSTS_ST_BOOTED 15

// ----------------------------------------------------------------
// Divider ratio bands, in hundredths
// ----------------------------------------------------------------
`define BSTS_PCT_LOW_MIN 7'd10
`define BSTS_PCT_HI_FREE 7'd60
`define BSTS_PCT_BAND 7'd10
`define BSTS_PCT_UNIT_MAX 7'd8
`define BSTS_PCT_FULL 7'd100

// ----------------------------------------------------------------
// Loaded sink path select bits
// ----------------------------------------------------------------
`define BSTS_SEL_HV0 0
`define BSTS_SEL_HV1 1
`define BSTS_SEL_EXT 2

`endif

// >>> bsts_pkg.sv
package bsts_pkg;

    // Dead-battery power-up modes
    typedef enum logic [2:0] {
        DB_NO_RESPONSE,
        DB_WAIT_AUX_INT,
        DB_WAIT_AUX_EXT,
        DB_RETRY_INT,
        DB_RETRY_EXT,
        DB_NO_WAIT
    } bsts_db_mode_t;

    // Fallback default configurations
    typedef enum logic [2:0] {
        DC_SAFE,
        DC_INF_WAIT,
        DC_PROF1,
        DC_PROF2,
        DC_PROF3,
        DC_PROF4,
        DC_PROF5,
        DC_RESERVED
    } bsts_dcfg_t;

    // Boot sequencer states
    typedef enum logic [2:0] {
        ST_STRAP,
        ST_INIT,
        ST_HOLD,
        ST_LOAD,
        ST_WAIT,
        ST_RETRY,
        ST_RUN
    } bsts_state_t;

endpackage

// >>> bsts_tick.sv
`timescale 1ns/1ps
// Slow timer tick divider
module bsts_tick #(
    parameter int DIV = 200
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] cnt_q;

    // ------------------------------------------------------------
    // Free-running divider
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule

// >>> bsts_chk.sv
`timescale 1ns/1ps
// Port-level checks
module bsts_chk #(
    parameter int NPATH = 2
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic AUX_SUPPLY_INPUT,
    input wire logic DIE_OVER_TEMP,
    input wire logic [NPATH-1:0] PATH_OVER_TEMP,
    input wire logic CFG_LOAD_REQ,
    input wire logic [NPATH-1:0] HIGH_VOLTAGE_PATH_EN,
    input wire logic EXTERNAL_SINK_CONTROL_PIN,
    input wire logic CORE_ENABLE,
    input wire logic BOOT_DONE,
    input bsts_pkg::bsts_db_mode_t DB_MODE,
    input bsts_pkg::bsts_dcfg_t DEFAULT_CFG
);
    import bsts_pkg::*;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    // Bus phases, switches open
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE;
    endsequence
    logic sw_off;
    assign sw_off = HIGH_VOLTAGE_PATH_EN == '0 && !EXTERNAL_SINK_CONTROL_PIN;

    a_ready_access: assert property (s_setup ##1 s_access |-> PREADY)
        else $error("no ready");
    a_ready_once: assert property (PREADY |=> !PREADY)
        else $error("ready too long");
    a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("stray error");
    a_req_pulse: assert property (CFG_LOAD_REQ |=> !CFG_LOAD_REQ)
        else $error("request too long");
    a_die_off: assert property (
        DIE_OVER_TEMP |=> ##1 !CORE_ENABLE && sw_off)
        else $error("die left output on");
    a_path_off: assert property (
        PATH_OVER_TEMP[0] |=> ##1 !HIGH_VOLTAGE_PATH_EN[0])
        else $error("hot path on");
    a_no_resp: assert property (
        DB_MODE == DB_NO_RESPONSE && !AUX_SUPPLY_INPUT && !BOOT_DONE
        |-> !CFG_LOAD_REQ && sw_off)
        else $error("acted without aux");
    a_strap_hold: assert property (
        !$past(SRST) && !$past(SRST, 2)
        |-> $stable(DB_MODE) && $stable(DEFAULT_CFG))
        else $error("straps moved");
    a_retry_pin: assert property (
        (DB_MODE == DB_RETRY_EXT && !AUX_SUPPLY_INPUT && CORE_ENABLE
        && !BOOT_DONE)[*3] |-> EXTERNAL_SINK_CONTROL_PIN)
        else $error("sink pin idle");
    a_nowait_sw: assert property (
        DB_MODE == DB_NO_WAIT && CFG_LOAD_REQ |-> sw_off)
        else $error("early switch");
endmodule

bind bsts_top bsts_chk #(.NPATH(NPATH)) u_chk (.*);

// >>> bsts_cfgmem_model.sv
`timescale 1ns/1ps
// Config memory: answers after lat cycles, failing nfail times
module bsts_cfgmem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [3:0] nfail,
    input wire logic [7:0] lat,
    output logic done,
    output logic fail
);
    logic busy_q;
    logic [7:0] wait_q;
    logic [3:0] tries_q;

    // Latency count, then answer
    always_ff @(posedge clk) begin
        done <= 1'b0;
        fail <= 1'b0;
        if (rst) begin
            busy_q <= 1'b0;
            wait_q <= 8'h00;
            tries_q <= 4'h0;
        end else if (req) begin
            busy_q <= 1'b1;
            wait_q <= lat;
        end else if (busy_q && wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            tries_q <= tries_q + 4'h1;
            fail <= tries_q < nfail;
            done <= tries_q >= nfail;
        end
    end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import bsts_pkg::*;
    localparam int NPATH = 2;
    logic CLOCK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic PREADY, PSLVERR, CFG_LOAD_REQ, CFG_LOAD_DONE, CFG_LOAD_FAIL, err;
    logic DIGITAL_STRAP_INPUT = 0, AUX_SUPPLY_INPUT = 0;
    logic DIE_OVER_TEMP = 0, DIE_COOLED = 1;
    logic [6:0] DIVIDER_RATIO_PCT = '0;
    logic [NPATH-1:0] PATH_OVER_TEMP = '0, PATH_COOLED = '1;
    logic [NPATH-1:0] HIGH_VOLTAGE_PATH_EN;
    logic [2:0] CFG_SINK_SEL = '0;
    logic EXTERNAL_SINK_CONTROL_PIN, CORE_ENABLE, CORE_CLK_LOW_POWER;
    logic PORT_ENABLE, LEGACY_SINK, SOURCE_ROLE, SINK_ROLE;
    logic PD_MSG_ENABLE, BOOT_DONE;
    bsts_db_mode_t DB_MODE;
    bsts_dcfg_t DEFAULT_CFG;
    logic [3:0] nfail = '0;
    logic [7:0] lat = 8'h40;
    int n_errors = 0, checks = 0, nreq = 0;

    bsts_top #(.NPATH(NPATH)) u_dut (.*);
    bsts_cfgmem_model u_mem (.clk(CLOCK), .rst(SRST), .req(CFG_LOAD_REQ),
        .nfail(nfail), .lat(lat), .done(CFG_LOAD_DONE), .fail(CFG_LOAD_FAIL));

    // Clock and load request counter
    initial begin
        forever #25 CLOCK = ~CLOCK;
    end
    always @(negedge CLOCK) if (CFG_LOAD_REQ === 1'b1) nreq++;

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge CLOCK);
        @(negedge CLOCK);
    endtask
    // Power-on with given straps, reset held 10 cycles
    task automatic boot(logic s, logic [6:0] p, logic a);
        @(posedge CLOCK);
        DIGITAL_STRAP_INPUT <= s;
        DIVIDER_RATIO_PCT <= p;
        AUX_SUPPLY_INPUT <= a;
        SRST <= 1;
        repeat (10) @(posedge CLOCK);
        SRST <= 0;
        nreq = 0;
        repeat (3) @(posedge CLOCK);
    endtask
    task automatic wboot(int lim);
        for (int i = 0; i < lim && BOOT_DONE !== 1'b1; i++) @(negedge CLOCK);
        chk("boot_done", BOOT_DONE, 1);
    endtask
    // One APB transfer; holds the request until ready is seen
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task automatic temp(logic d, logic dc, logic [1:0] o, logic [1:0] c);
        @(posedge CLOCK);
        DIE_OVER_TEMP <= d;
        DIE_COOLED <= dc;
        PATH_OVER_TEMP <= o;
        PATH_COOLED <= c;
        wt(3);
    endtask

    // Strap rows at band edges, then straps moved
    task automatic t_decode();
        logic [6:0] p[15] = '{7'h12, 7'h14, 7'h26, 7'h28, 7'h3A, 7'h3C,
            7'h0A, 7'h1C, 7'h1E, 7'h30, 7'h32, 7'h44, 7'h46, 7'h58, 7'h64};
        logic [5:0] e[15] = '{6'h00, 6'h08, 6'h19, 6'h10, 6'h21, 6'h28,
            6'h02, 6'h03, 6'h19, 6'h2C, 6'h21, 6'h05, 6'h2F, 6'h07, 6'h2E};
        for (int i = 0; i < 15; i++) begin
            boot(i < 6, p[i], 1);
            wt(0);
            chk("decode", {DB_MODE, DEFAULT_CFG}, e[i]);
        end
        temp(0, 1, 2'h0, 2'h3);
        @(posedge CLOCK);
        DIVIDER_RATIO_PCT <= 7'h05;
        DIGITAL_STRAP_INPUT <= 1;
        wt(3);
        chk("strap_hold", {DB_MODE, DEFAULT_CFG}, 6'h2E);
    endtask
    // Wait-for-aux internal: path 0 closed, no load until aux
    task automatic t_wait();
        boot(1, 7'h19, 0);
        wt(1200);
        chk("wait_path", HIGH_VOLTAGE_PATH_EN, 2'h1);
        chk("wait_noreq", nreq, 0);
        @(posedge CLOCK);
        AUX_SUPPLY_INPUT <= 1;
        wboot(3000);
        chk("wait_req", nreq, 1);
    endtask
    // No-wait: load on VBUS, then close the loaded choice
    task automatic t_nowait();
        boot(0, 7'h5F, 0);
        CFG_SINK_SEL <= 3'h1;
        wboot(3000);
        chk("nw_req", nreq, 1);
        chk("nw_path", HIGH_VOLTAGE_PATH_EN, 2'h1);
        chk("nw_ext", EXTERNAL_SINK_CONTROL_PIN, 0);
        chk("nw_pd", PD_MSG_ENABLE, 1);
        apb(0, 12'h008, 0);
        chk("nw_stat", rd[9:8], 2'h1);
    endtask
    // Retry external: first load fails, second loads
    task automatic t_retry();
        boot(1, 7'h37, 0);
        nfail <= 4'h1;
        CFG_SINK_SEL <= 3'h4;
        wt(20);
        chk("rt_ext", EXTERNAL_SINK_CONTROL_PIN, 1);
        chk("rt_path", HIGH_VOLTAGE_PATH_EN, 2'h0);
        wboot(25000);
        chk("rt_req", nreq, 2);
        apb(0, 12'h008, 0);
        chk("rt_stat", rd[9:8], 2'h1);
    endtask
    // Safe default, then thermal and bus checks
    task automatic t_safe();
        boot(1, 7'h3C, 0);
        nfail <= 4'hF;
        wboot(3000);
        chk("sf_req", nreq, 1);
        chk("sf_port", PORT_ENABLE, 0);
        chk("sf_legacy", LEGACY_SINK, 1);
        chk("sf_roles", {SOURCE_ROLE, SINK_ROLE, PD_MSG_ENABLE}, 0);
        chk("sf_path", HIGH_VOLTAGE_PATH_EN, 2'h1);
        apb(0, 12'h008, 0);
        chk("sf_stat", rd[9:8], 2'h2);
        temp(0, 1, 2'h1, 2'h2);
        chk("hot_path", HIGH_VOLTAGE_PATH_EN, 2'h0);
        apb(0, 12'h008, 0);
        chk("hot_stat", rd[13:12], 2'h1);
        temp(0, 1, 2'h0, 2'h3);
        chk("cool_held", HIGH_VOLTAGE_PATH_EN, 2'h0);
        apb(1, 12'h004, 32'h0000_0001);
        wt(3);
        chk("reenable", HIGH_VOLTAGE_PATH_EN, 2'h1);
        apb(1, 12'h000, 32'h0000_0001);
        temp(0, 1, 2'h1, 2'h2);
        temp(0, 1, 2'h0, 2'h3);
        chk("auto_resume", HIGH_VOLTAGE_PATH_EN, 2'h1);
        temp(1, 0, 2'h0, 2'h3);
        chk("die_core", CORE_ENABLE, 0);
        chk("die_path", HIGH_VOLTAGE_PATH_EN, 2'h0);
        temp(0, 0, 2'h0, 2'h3);
        chk("die_hyst", CORE_ENABLE, 0);
        temp(0, 1, 2'h0, 2'h3);
        chk("die_back", CORE_ENABLE, 1);
        apb(0, 12'h00C, 0);
        chk("bad_err", err, 1);
        chk("bad_rd", rd, 0);
        apb(1, 12'h000, 32'h0000_0003);
        apb(0, 12'h000, 0);
        chk("ctrl_rd", rd, 32'h0000_0003);
        wt(1);
        chk("low_power", CORE_CLK_LOW_POWER, 1);
        apb(0, 12'h004, 0);
        chk("reen_rd", rd, 0);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (40000) @(posedge CLOCK);
        n_errors++;
        test_done();
    end
    // Main sequence
    initial begin
        t_decode();
        $display("test decode done");
        t_wait();
        $display("test wait done");
        t_nowait();
        $display("test nowait done");
        t_retry();
        $display("test retry done");
        t_safe();
        $display("test safe done");
        test_done();
    end
endmodule
